// >>> hdl/bars_pkg.sv
// Shared constants and types of the bridge converter serial readout block
package bars_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 24;                 // Result code width
  localparam int RAW_W  = 26;                 // Modulator word width, with headroom
  localparam int CNT_W  = 5;                  // Pulse counter width
  localparam int TMR_W  = 22;                 // Conversion timer width
  localparam int PD_W   = 11;                 // Power-down timer width
  localparam int ACT_W  = 8;                  // Crystal activity timer width

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 20_000_000;     // Core clock rate
  localparam int INT_SPS_LO = 10;             // Results per second, rate pin low
  localparam int INT_SPS_HI = 80;             // Results per second, rate pin high
  localparam int INT_CYC_LO = CLK_HZ / INT_SPS_LO;
  localparam int INT_CYC_HI = CLK_HZ / INT_SPS_HI;
  localparam int EXT_DIV_LO = 1_105_920;      // Source periods per result, rate low
  localparam int EXT_DIV_HI = 138_240;        // Source periods per result, rate high
  localparam int PD_TIME_US = 60;             // High time that means power down
  localparam int PD_CYC     = (PD_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam logic [PD_W-1:0] PD_CYC_L = PD_W'(PD_CYC);
  localparam logic [ACT_W-1:0] ACT_WIN = 8'hFF; // Quiet cycles before source is lost

  // ****************************************
  // Codes and pulse counts
  // ****************************************
  localparam logic [DATA_W-1:0] CODE_MAX = 24'h7FFFFF;
  localparam logic [DATA_W-1:0] CODE_MIN = 24'h800000;
  localparam logic [CNT_W-1:0]  PULSES_A128 = 5'h19;
  localparam logic [CNT_W-1:0]  PULSES_B32  = 5'h1A;
  localparam logic [CNT_W-1:0]  PULSES_A64  = 5'h1B;
  localparam logic [CNT_W-1:0]  LAST_BIT    = 5'h18;
  localparam logic [CNT_W-1:0]  CNT_MAX     = 5'h1F;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_PULSES = 8'h0C;
  localparam logic [1:0] CTRL_RST   = 2'h1;   // Running, oscillator auto
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_INT_BIT = 1;
  localparam int ST_ERR_BIT   = 8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READY = 2'h1,
    ST_SHIFT = 2'h3,
    ST_DOWN  = 2'h2
  } bars_state_e;

  typedef enum logic [1:0] {
    GAIN_128 = 2'h0,
    GAIN_32  = 2'h1,
    GAIN_64  = 2'h2
  } bars_gain_e;

endpackage : bars_pkg

// >>> hdl/bars_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module bars_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,   // Core clock
  input  wire logic             rst_n_in, // Synchronous reset, active low
  input  wire logic             ce_in,    // Clock enable
  input  wire logic [WIDTH-1:0] d_in,     // Asynchronous levels
  output logic      [WIDTH-1:0] q_out     // Synchronised levels
);

  // ****************************************
  // Stages
  // ****************************************
  logic [WIDTH-1:0] meta;

  // First stage feeds the second only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else if (ce_in) begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : bars_sync

// >>> hdl/bars_core.sv
// Serial readout, conversion timing and power-down control of the bridge converter
`timescale 1ns/100ps
// Behaviour
// - Data line stays high while no unread result exists
// - Data line goes low when a fresh result is ready
// - Each rising pulse presents one result bit, MSB first, 24 bits
// - Twenty-fifth pulse returns data line high until next result
// - Pulse count 25/26/27 selects A128, B32, A64 for next conversion
// - Results are 24-bit two's complement
// - Out-of-range input clamps to most negative or positive code
// - Clock pin high beyond 60 us enters power down
// - Clock pin low after power down resets and resumes converting
// - After reset or power down, channel A gain 128 is chosen
// - All state resets on power-up without host action
// - Internal oscillator gives 10 or 80 results per second by rate pin
// - Oscillator enabled when crystal input is grounded
// - Oscillator disabled while a crystal or external clock runs (kept on here while CTRL_INT_BIT is set)
// - External rate scales with source; 11.0592 MHz gives 10 or 80
// - External period is 1,105,920 or 138,240 source periods
module bars_core #(
  parameter int INT_CYC_LO = bars_pkg::INT_CYC_LO, // Core cycles per result, rate low
  parameter int INT_CYC_HI = bars_pkg::INT_CYC_HI, // Core cycles per result, rate high
  parameter int EXT_DIV_LO = bars_pkg::EXT_DIV_LO, // Source edges per result, rate low
  parameter int EXT_DIV_HI = bars_pkg::EXT_DIV_HI  // Source edges per result, rate high
) (
  input  wire logic                       clk_in,                        // Core clock
  input  wire logic                       rst_n_in,                      // Reset, active low
  input  wire logic                       ce_in,                         // Clock enable
  input  wire logic                       shift_clock_powerdown_pin_in,  // Host clock pin
  input  wire logic                       crystal_input_pin_in,          // Source pin
  input  wire logic                       rate_pin_in,                   // Rate select pin
  input  wire logic [bars_pkg::RAW_W-1:0] raw_sample_in,                 // Modulator word
  output logic                            data_out,                      // Serial data pin
  output logic                            powerdown_out,                 // Power-down state
  output logic                            osc_enable_out,                // Oscillator enable
  output logic                            chan_b_out,                    // Channel B chosen
  output logic [1:0]                      gain_out,                      // Gain code
  input  wire logic                       wb_cyc_in,                     // Bus cycle
  input  wire logic                       wb_stb_in,                     // Bus strobe
  input  wire logic                       wb_we_in,                      // Bus write
  input  wire logic [7:0]                 wb_adr_in,                     // Byte address
  input  wire logic [3:0]                 wb_sel_in,                     // Byte lanes
  input  wire logic [31:0]                wb_dat_in,                     // Write data
  output logic [31:0]                     wb_dat_out,                    // Read data
  output logic                            wb_ack_out                     // Bus acknowledge
);
  import bars_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pins_s;
  logic       sck_s;
  logic       xtal_s;
  logic       rate_s;
  logic       sck_d;
  logic       xtal_d;

  bars_sync #(.WIDTH(3)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .d_in     ({shift_clock_powerdown_pin_in, crystal_input_pin_in, rate_pin_in}),
    .q_out    (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign xtal_s = pins_s[1];
  assign rate_s = pins_s[0];

  // Edge history taken from the synchronised copies only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sck_d  <= 1'b0;
      xtal_d <= 1'b0;
    end else if (ce_in) begin
      sck_d  <= sck_s;
      xtal_d <= xtal_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d;
  wire ext_edge = xtal_s & ~xtal_d;

  // ****************************************
  // Declarations
  // ****************************************
  bars_state_e       state;
  bars_state_e       next_state;
  bars_gain_e        gain;
  bars_gain_e        next_gain;
  logic [CNT_W-1:0]  pcnt;
  logic [CNT_W-1:0]  next_pcnt;
  logic [CNT_W-1:0]  last_pulses;
  logic [CNT_W-1:0]  next_last;
  logic [DATA_W-1:0] shreg;
  logic [DATA_W-1:0] next_shreg;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic              dout;
  logic              next_dout;
  logic              err_evt;
  logic              serial_err;
  logic [1:0]        ctrl;
  logic [PD_W-1:0]   hi_cnt;
  logic [TMR_W-1:0]  tmr;
  logic [ACT_W-1:0]  act_cnt;
  logic              ext_active;
  logic              osc_en;
  logic              ack;
  logic [31:0]       rd_q;

  // ****************************************
  // Clock source detection
  // ****************************************
  // A quiet crystal pin means grounded; the source must toggle slower than clk/2
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      act_cnt    <= '0;
      ext_active <= 1'b0;
    end else if (ce_in) begin
      if (ext_edge) begin
        act_cnt    <= '0;
        ext_active <= 1'b1;
      end else if (act_cnt == ACT_WIN) begin
        ext_active <= 1'b0;
      end else begin
        act_cnt <= act_cnt + 8'h01;
      end
    end
  end

  wire use_ext = ext_active & ~ctrl[CTRL_INT_BIT];

  // Oscillator runs while no outside source is seen or CTRL_INT_BIT of ctrl is set
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) osc_en <= 1'b1;
    else if (ce_in) osc_en <= ~use_ext;
  end

  // ****************************************
  // Conversion timer
  // ****************************************
  // Period: core cycles on the oscillator, source edges otherwise
  wire [TMR_W-1:0] int_m1 = rate_s ? TMR_W'(INT_CYC_HI - 1) : TMR_W'(INT_CYC_LO - 1);
  wire [TMR_W-1:0] ext_m1 = rate_s ? TMR_W'(EXT_DIV_HI - 1) : TMR_W'(EXT_DIV_LO - 1);
  wire [TMR_W-1:0] tgt_m1 = use_ext ? ext_m1 : int_m1;
  wire             tick   = use_ext ? ext_edge : 1'b1;
  wire             run    = ctrl[CTRL_RUN_BIT] & (state != ST_DOWN);
  // Greater-or-equal keeps a rate change from stretching one period to wrap
  wire             conv_done = run & tick & (tmr >= tgt_m1);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) tmr <= '0;
    else if (ce_in) begin
      if (!run || conv_done) tmr <= '0;
      else if (tick) tmr <= tmr + 22'h000001;
    end
  end

  // ****************************************
  // Result clamp
  // ****************************************
  // In range when every headroom bit equals the result sign bit
  wire in_range = (raw_sample_in[RAW_W-1:DATA_W-1] == '0)
                | (raw_sample_in[RAW_W-1:DATA_W-1] == '1);
  wire [DATA_W-1:0] clamped = in_range ? raw_sample_in[DATA_W-1:0]
                            : (raw_sample_in[RAW_W-1] ? CODE_MIN : CODE_MAX);

  // ****************************************
  // Power-down detection
  // ****************************************
  wire pd_enter = sck_s & (hi_cnt == PD_CYC_L) & (state != ST_DOWN);

  // Counts high samples; saturates so a long high does not wrap
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) hi_cnt <= '0;
    else if (ce_in) begin
      if (!sck_s) hi_cnt <= '0;
      else if (hi_cnt != PD_CYC_L) hi_cnt <= hi_cnt + 11'h001;
    end
  end

  // ****************************************
  // Readout state machine
  // ****************************************
  wire [CNT_W-1:0] pcnt_inc = (pcnt == CNT_MAX) ? pcnt : pcnt + 5'h01;
  wire             accept   = conv_done & ~sck_rise & (state != ST_SHIFT);

  always_comb begin
    next_state  = state;
    next_gain   = gain;
    next_pcnt   = pcnt;
    next_last   = last_pulses;
    next_shreg  = shreg;
    next_result = result;
    next_dout   = dout;
    err_evt     = 1'b0;
    if (pd_enter) begin
      next_state = ST_DOWN;
      next_dout  = 1'b1;
    end else begin
      unique case (state)
        ST_DOWN: begin
          if (!sck_s) begin
            next_state = ST_IDLE;
            next_pcnt  = '0;
            next_gain  = GAIN_128;
          end
        end
        ST_IDLE, ST_READY, ST_SHIFT: begin
          if (sck_rise) begin
            next_pcnt = pcnt_inc;
            if (state == ST_READY || (state == ST_SHIFT && pcnt < LAST_BIT)) begin
              next_dout  = shreg[DATA_W-1];
              next_shreg = {shreg[DATA_W-2:0], 1'b0};
              next_state = ST_SHIFT;
            end else if (state == ST_SHIFT) begin
              next_dout  = 1'b1;
              next_state = ST_IDLE;
            end
          end
          if (accept) begin
            next_result = clamped;
            next_shreg  = clamped;
            next_dout   = 1'b0;
            next_state  = ST_READY;
            next_pcnt   = '0;
            next_last   = pcnt;
            // Selection lands now, so it steers the conversion just starting
            if (pcnt == PULSES_A128) next_gain = GAIN_128;
            else if (pcnt == PULSES_B32) next_gain = GAIN_32;
            else if (pcnt == PULSES_A64) next_gain = GAIN_64;
            else if (pcnt != '0) err_evt = 1'b1;
          end
        end
      endcase
    end
  end

  // Power-on reset is the synchronous reset; no host action needed
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state       <= ST_IDLE;
      gain        <= GAIN_128;
      pcnt        <= '0;
      last_pulses <= '0;
      shreg       <= '0;
      result      <= '0;
      dout        <= 1'b1;
    end else if (ce_in) begin
      state       <= next_state;
      gain        <= next_gain;
      pcnt        <= next_pcnt;
      last_pulses <= next_last;
      shreg       <= next_shreg;
      result      <= next_result;
      dout        <= next_dout;
    end
  end

  assign data_out       = dout;
  assign powerdown_out  = (state == ST_DOWN);
  assign osc_enable_out = osc_en;
  assign chan_b_out     = (gain == GAIN_32);
  assign gain_out       = gain;

  // ****************************************
  // Wishbone slave
  // ****************************************
  wire bus_req  = wb_cyc_in & wb_stb_in;
  wire wr_take  = bus_req & wb_we_in & ack;
  wire hit_ctrl = (wb_adr_in == REG_CTRL);
  wire hit_stat = (wb_adr_in == REG_STATUS);
  wire hit_res  = (wb_adr_in == REG_RESULT);
  wire hit_pul  = (wb_adr_in == REG_PULSES);
  wire err_clr  = wr_take & hit_stat & wb_sel_in[1] & wb_dat_in[ST_ERR_BIT];
  wire [31:0] status_w = {23'h000000, serial_err, 2'h0, gain, chan_b_out,
                          use_ext, powerdown_out, (state == ST_READY)};
  wire [31:0] rd_data = hit_ctrl ? {30'h00000000, ctrl}
                      : hit_stat ? status_w
                      : hit_res  ? {8'h00, result}
                      : hit_pul  ? {27'h0000000, last_pulses}
                      : 32'h00000000;

  // One wait state; unmapped reads give zero, unmapped writes vanish
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack  <= 1'b0;
      rd_q <= '0;
    end else if (ce_in) begin
      ack  <= bus_req & ~ack;
      if (bus_req && !ack) rd_q <= rd_data;
    end
  end

  // Writes land on the acknowledge edge, where the master samples ack
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) ctrl <= CTRL_RST;
    else if (ce_in && wr_take && hit_ctrl && wb_sel_in[0]) ctrl <= wb_dat_in[1:0];
  end

  // Sticky error: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) serial_err <= 1'b0;
    else if (ce_in) serial_err <= err_evt | (serial_err & ~err_clr);
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = rd_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in iff ce_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_rise_ready;
    sck_rise && state == ST_READY && !pd_enter;
  endsequence

  sequence s_rise_mid;
    sck_rise && state == ST_SHIFT && pcnt < LAST_BIT && !pd_enter;
  endsequence

  sequence s_take(logic [CNT_W-1:0] n);
    accept && !pd_enter && pcnt == n;
  endsequence

  AST_IDLE_HIGH: assert property ((state == ST_IDLE || state == ST_DOWN) |-> data_out)
    else $error("data line low without a pending result");
  AST_READY_LOW: assert property (accept && !pd_enter |=> !data_out && state == ST_READY)
    else $error("fresh result did not pull data line low");
  AST_MSB_FIRST: assert property (s_rise_ready |=> data_out == $past(result[DATA_W-1]))
    else $error("first pulse did not present the top bit");
  AST_BIT_ORDER: assert property (s_rise_mid
                                  |=> data_out == $past(shreg[DATA_W-1]))
    else $error("shifted bit out of order");
  AST_25TH_HIGH: assert property (sck_rise && state == ST_SHIFT && pcnt == LAST_BIT && !pd_enter
                                  |=> data_out && state == ST_IDLE)
    else $error("twenty-fifth pulse left data line low");
  AST_SEL_B32: assert property (s_take(PULSES_B32) |=> chan_b_out && gain_out == GAIN_32)
    else $error("26 pulses did not select channel B");
  AST_SEL_A64: assert property (s_take(PULSES_A64) |=> !chan_b_out && gain_out == GAIN_64)
    else $error("27 pulses did not select gain 64");
  AST_ERR_SET: assert property (accept && !pd_enter && pcnt != '0
                                && (pcnt < PULSES_A128 || pcnt > PULSES_A64) |=> serial_err)
    else $error("bad pulse count not flagged");
  AST_CLAMP_HI: assert property (accept && !pd_enter && !in_range && !raw_sample_in[RAW_W-1]
                                 |=> result == CODE_MAX)
    else $error("positive overrange not clamped");
  AST_CLAMP_LO: assert property (accept && !pd_enter && !in_range && raw_sample_in[RAW_W-1]
                                 |=> result == CODE_MIN)
    else $error("negative overrange not clamped");
  AST_PD_ENTRY: assert property ($rose(state == ST_DOWN) |-> $past(hi_cnt) == PD_CYC_L
                                 && $past(sck_s))
    else $error("power down entered at the wrong time");
  AST_PD_EXIT: assert property (state == ST_DOWN && !sck_s
                                |=> state == ST_IDLE && gain_out == GAIN_128 && data_out)
    else $error("power down exit did not reset selection");
  AST_OSC_OFF: assert property (use_ext |=> !osc_enable_out)
    else $error("oscillator left on with outside source");

endmodule : bars_core

// >>> test/bars_host_model.sv
// Host model that bit-bangs the shift clock pin and reads serial data
`timescale 1ns/100ps
module bars_host_model (
  input  wire logic clk_in,   // Core clock
  input  wire logic data_in,  // Serial data from device
  output logic      pin_out   // Shift clock and power-down pin
);
  // ****************************************
  // Link driving
  // ****************************************
  // Link clock stands still low outside frames
  initial pin_out = 1'b0;

  // One 200 ns pulse; data is taken after the fall, while it is settled
  task automatic pulse(output logic bit_v);
    @(posedge clk_in) pin_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    pin_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    bit_v = data_in;
  endtask : pulse

  // Frame of 24 bits MSB first; counts outside 25 to 27 only for error tests
  task automatic readout(input int pulses, output logic [23:0] word);
    logic b;
    word = '0;
    for (int i = 0; i < pulses; i++) begin
      pulse(b);
      if (i < 24) word = {word[22:0], b};
    end
  endtask : readout

  // Level held for a number of cycles, used for power down
  task automatic set_pin(input logic v, input int cycles);
    @(posedge clk_in) pin_out <= v;
    repeat (cycles) @(posedge clk_in);
  endtask : set_pin
endmodule : bars_host_model

// >>> test/bars_core_tb.sv
// Self-checking testbench of the serial readout core
`timescale 1ns/100ps
module bars_core_tb;
  import bars_pkg::*;
  localparam int LIMIT  = 20000; // Run needs about 13000 cycles
  localparam int CYC_LO = 2000;  // Core cycles per result, rate low
  localparam int CYC_HI = 1000;  // Core cycles per result, rate high
  logic             rate     = 1'b0;
  logic [3:0]       sel      = 4'h0;
  logic             clk_in   = 1'b0;
  logic             rst_n_in = 1'b0;
  logic             pin, data, pd, osc, chan_b, ack;
  logic             xtal     = 1'b0;
  logic [RAW_W-1:0] raw      = '0;
  logic [1:0]       gain;
  logic             cyc      = 1'b0;
  logic             stb      = 1'b0;
  logic             we       = 1'b0;
  logic [7:0]       adr      = '0;
  logic [31:0]      wdat     = '0;
  logic [31:0]      rdat;
  int               fails    = 0;
  int               checked  = 0;
  int               cycles   = 0;

  always #25 clk_in = ~clk_in;

  // Short conversion periods keep the run small
  bars_core #(.INT_CYC_LO(CYC_LO), .INT_CYC_HI(CYC_HI), .EXT_DIV_LO(40), .EXT_DIV_HI(20)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .shift_clock_powerdown_pin_in(pin), .crystal_input_pin_in(xtal), .rate_pin_in(rate),
    .raw_sample_in(raw), .data_out(data), .powerdown_out(pd), .osc_enable_out(osc),
    .chan_b_out(chan_b), .gain_out(gain), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack));

  bars_host_model host_u (.clk_in(clk_in), .data_in(data), .pin_out(pin));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Classic cycle held until ack is sampled, then released
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= wd;
    do @(posedge clk_in); while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask : wb_cycle

  task automatic end_of_test;
    $display("Counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    cmp("data idle", 32'h1, data);
    cmp("selection", 32'h0, {chan_b, gain});
    cmp("power state", 32'h0, pd);
    $display("test_reset done");
  endtask : test_reset

  // Each count is judged at the following ready, when its selection lands
  task automatic test_readouts;
    logic [25:0] raws [3] = '{26'h0123456, 26'h0900000, 26'h3000000};
    logic [23:0] exps [3] = '{24'h123456, 24'h7FFFFF, 24'h800000};
    int          cnts [3] = '{26, 25, 27};
    logic [2:0]  sels [4] = '{3'h0, 3'h5, 3'h0, 3'h2};
    logic [23:0] word;
    logic [31:0] rd;
    for (int i = 0; i < 4; i++) begin
      if (i < 3) raw <= raws[i];
      while (data !== 1'b0) @(posedge clk_in);
      cmp("selection", {29'h0, sels[i]}, {chan_b, gain});
      if (i < 3) begin
        host_u.readout(cnts[i], word);
        cmp("result word", exps[i], word);
        cmp("data after frame", 32'h1, data);
        wb_cycle(1'b0, REG_RESULT, '0, rd);
        cmp("result reg", exps[i], rd);
      end
    end
    wb_cycle(1'b1, 8'hF0, 32'hFFFFFFFF, rd);
    wb_cycle(1'b0, 8'hF0, '0, rd);
    cmp("unmapped read", 32'h0, rd);
    $display("test_readouts done");
  endtask : test_readouts

  task automatic test_powerdown;
    host_u.set_pin(1'b1, 1300);
    cmp("power down", 32'h1, pd);
    host_u.set_pin(1'b0, 6);
    cmp("power up", 32'h0, pd);
    cmp("selection", 32'h0, {chan_b, gain});
    cmp("data idle", 32'h1, data);
    $display("test_powerdown done");
  endtask : test_powerdown

  // Toggling source pin turns the oscillator off; grounded turns it on
  task automatic test_crystal;
    for (int i = 0; i < 40; i++) begin
      repeat (4) @(posedge clk_in);
      xtal <= ~xtal;
    end
    cmp("osc off", 32'h0, osc);
    repeat (300) @(posedge clk_in);
    cmp("osc on", 32'h1, osc);
    $display("test_crystal done");
  endtask : test_crystal

  // Rate pin high gives the short period; a 28-pulse frame sets the sticky error
  task automatic test_rate_status;
    logic [23:0] word;
    logic [31:0] rd;
    int          t0;
    rate <= 1'b1;
    while (data !== 1'b0) @(posedge clk_in);
    host_u.readout(28, word);
    while (data !== 1'b0) @(posedge clk_in);
    t0 = cycles;
    wb_cycle(1'b0, REG_STATUS, '0, rd);
    cmp("status error", 32'h101, rd);
    wb_cycle(1'b0, REG_PULSES, '0, rd);
    cmp("pulse count", 32'h1C, rd);
    wb_cycle(1'b1, REG_STATUS, 32'h100, rd);
    wb_cycle(1'b0, REG_STATUS, '0, rd);
    cmp("status cleared", 32'h1, rd);
    host_u.readout(25, word);
    while (data !== 1'b0) @(posedge clk_in);
    cmp("fast period", CYC_HI, cycles - t0);
    $display("test_rate_status done");
  endtask : test_rate_status

  // Hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    test_reset();
    test_readouts();
    test_powerdown();
    test_crystal();
    test_rate_status();
    end_of_test();
  end
endmodule : bars_core_tb
